// *** rtl/scs_defines.vh ***
// constants for the start-up configuration and status block
`ifndef SCS_DEFINES_VH
`define SCS_DEFINES_VH
`define SCS_UNIT_MAX 4'hF
`define SCS_ADDR_OFFSET 8'h10
`define SCS_LOG_BATTERY 16'h0330
`define SCS_LOG_DATABASE 16'h0331
`define SCS_RELAY_BAT_BIT 5
`define SCS_CLK_KHZ 20000
`define SCS_BLINK_HALF_MS 500
`define SCS_BLINK_HALF_CYC (`SCS_BLINK_HALF_MS * `SCS_CLK_KHZ)
`define SCS_SETTLE_CYC 4
`define SCS_ST_INIT 3'h0
`define SCS_ST_COPY 3'h1
`define SCS_ST_STOP 3'h2
`define SCS_ST_PUBL 3'h3
`define SCS_ST_RUN 3'h4
`define SCS_ST_HALT 3'h5
`endif

// *** rtl/scs_startup_config_status.v ***
// start-up configuration, backup restore and status indicators
// Contract
// - the module number 0..F is read from the rotary selector pins.
// - on start of running the address number+10h goes to unit_address_item.
// - the same address is written to the first word of each loop area.
// - the auxiliary serial port is enabled only when its block exists.
// - the run lamp is lit only while running, dark in every other state.
// - the fault lamp is lit on module error and blinks on battery error.
// - with pin 2 off a low battery sets relay bit 05 and the fault item.
// - battery error logs code 0330 and database error logs code 0331.
// - with pin 2 on flash is copied to RAM, then bit 5 and item are set.
// - with pin 2 on no battery code 0330 enters the error log.
// - with pin 2 on a low battery never makes the fault lamp blink.
// - switches are sampled only after reset; later changes are ignored.
// - after a restore the copy ends before running and only cold starts.
// - after a stop by the tool both hot and cold starts are accepted.
// - block data and error log are held in the backed-up RAM arrays.
`timescale 1ns/1ps
`include "scs_defines.vh"
module scs_startup_config_status #(
  parameter RAM_AW = 6,
  parameter LOG_AW = 4,
  parameter NUM_LOOPS = 4,
  parameter [15:0] AREA_BASE = 16'h0000,
  parameter [15:0] AREA_STRIDE = 16'h0100,
  parameter BLINK_HALF_CYC = `SCS_BLINK_HALF_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // front panel and battery pins
  input wire [3:0] unit_sel,
  input wire restore_sw,
  input wire battery_low,
  // host and tool controls
  input wire start_req,
  input wire start_cold,
  input wire stop_req,
  input wire term_block_present,
  input wire db_error,
  input wire hw_fault,
  input wire wdt_error,
  input wire supply_ok,
  input wire host_error,
  // flash read port
  output reg [RAM_AW-1:0] flash_addr,
  input wire [15:0] flash_rdata,
  // block data access
  input wire ram_we,
  input wire [RAM_AW-1:0] ram_addr,
  input wire [15:0] ram_wdata,
  output reg [15:0] ram_rdata,
  // error log access
  input wire [LOG_AW-1:0] log_raddr,
  output reg [15:0] log_rdata,
  output reg [LOG_AW:0] log_count,
  // shared node data memory write port
  output reg node_we,
  output reg [15:0] node_addr,
  output reg [15:0] node_wdata,
  // status
  output reg [7:0] unit_address_item,
  output reg battery_fault_item,
  output reg relay_word_bit5,
  output reg aux_port_en,
  output reg cold_only,
  output reg start_refused,
  output reg running,
  output reg run_lamp,
  output reg module_fault_lamp,
  output reg host_fault_lamp
);
  reg [15:0] fb_ram [0:(1<<RAM_AW)-1];
  reg [15:0] err_log [0:(1<<LOG_AW)-1];
  reg [3:0] sel_s1, sel_s2, sel_s3;
  reg [2:0] sw_s, bat_s;
  reg [3:0] unit_num;
  reg restore_on;
  reg bat_stable;
  reg [2:0] state;
  reg [2:0] settle;
  reg [RAM_AW:0] copy_cnt;
  reg [7:0] loop_cnt;
  reg [31:0] blink_cnt;
  reg blink;
  reg bat_err;
  reg bat_logged;
  reg db_pend;
  reg db_flag;
  reg fault_run;
  wire sel_agree;
  wire [7:0] unit_addr;
  wire [15:0] area_addr;
  wire log_bat;
  wire log_db;
  wire log_full;

  // pin synchronisers, change counted when second and third agree
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_s1 <= 4'h0;
      sel_s2 <= 4'h0;
      sel_s3 <= 4'h0;
      sw_s <= 3'h0;
      bat_s <= 3'h0;
      bat_stable <= 1'b0;
    end else begin
      sel_s1 <= unit_sel;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      sw_s <= {sw_s[1:0], restore_sw};
      bat_s <= {bat_s[1:0], battery_low};
      if (bat_s[1] == bat_s[2]) begin
        bat_stable <= bat_s[2];
      end
    end
  end

  assign sel_agree = (sel_s2 == sel_s3) && (sw_s[1] == sw_s[2]);
  assign unit_addr = {4'h0, unit_num} + `SCS_ADDR_OFFSET;
  assign area_addr = AREA_BASE + (loop_cnt * AREA_STRIDE);
  assign log_full = log_count[LOG_AW];
  // battery log only with pin 2 off, once per detection
  assign log_bat = bat_err && !bat_logged && !restore_on;
  assign log_db = db_pend && !log_bat;

  // start-up sequencer
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= `SCS_ST_INIT;
      settle <= 3'h0;
      unit_num <= 4'h0;
      restore_on <= 1'b0;
      copy_cnt <= {(RAM_AW+1){1'b0}};
      flash_addr <= {RAM_AW{1'b0}};
      loop_cnt <= 8'h00;
      cold_only <= 1'b0;
      start_refused <= 1'b0;
      running <= 1'b0;
      unit_address_item <= 8'h00;
      node_we <= 1'b0;
      node_addr <= 16'h0000;
      node_wdata <= 16'h0000;
    end else begin
      start_refused <= 1'b0;
      node_we <= 1'b0;
      case (state)
        `SCS_ST_INIT: begin
          if (!sel_agree) begin
            settle <= 3'h0;
          end else if (settle == `SCS_SETTLE_CYC) begin
            unit_num <= sel_s3;
            restore_on <= sw_s[2];
            copy_cnt <= {(RAM_AW+1){1'b0}};
            flash_addr <= {RAM_AW{1'b0}};
            if (sw_s[2]) begin
              cold_only <= 1'b1;
              state <= `SCS_ST_COPY;
            end else begin
              state <= `SCS_ST_STOP;
            end
          end else begin
            settle <= settle + 3'h1;
          end
        end
        `SCS_ST_COPY: begin
          // flash data arrives one cycle after its address
          copy_cnt <= copy_cnt + 1'b1;
          flash_addr <= flash_addr + 1'b1;
          if (copy_cnt == (1 << RAM_AW)) begin
            state <= `SCS_ST_STOP;
          end
        end
        `SCS_ST_STOP: begin
          running <= 1'b0;
          if (start_req && supply_ok && !hw_fault && !wdt_error) begin
            if (cold_only && !start_cold) begin
              start_refused <= 1'b1;
            end else begin
              unit_address_item <= unit_addr;
              loop_cnt <= 8'h00;
              state <= `SCS_ST_PUBL;
            end
          end
        end
        `SCS_ST_PUBL: begin
          node_we <= 1'b1;
          node_addr <= area_addr;
          node_wdata <= {8'h00, unit_address_item};
          loop_cnt <= loop_cnt + 8'h01;
          if (loop_cnt == NUM_LOOPS - 1) begin
            running <= 1'b1;
            state <= `SCS_ST_RUN;
          end
        end
        `SCS_ST_RUN: begin
          if (hw_fault || wdt_error || !supply_ok) begin
            running <= 1'b0;
            state <= `SCS_ST_HALT;
          end else if (stop_req) begin
            running <= 1'b0;
            cold_only <= 1'b0;
            state <= `SCS_ST_STOP;
          end
        end
        `SCS_ST_HALT: begin
          running <= 1'b0;
        end
        default: begin
          state <= `SCS_ST_INIT;
        end
      endcase
    end
  end

  // backed-up block data and error log arrays
  always @(posedge ref_clk) begin
    if (state == `SCS_ST_COPY && copy_cnt != 0) begin
      fb_ram[copy_cnt[RAM_AW-1:0] - 1'b1] <= flash_rdata;
    end else if (ram_we) begin
      fb_ram[ram_addr] <= ram_wdata;
    end
    if (!log_full && log_bat) begin
      err_log[log_count[LOG_AW-1:0]] <= `SCS_LOG_BATTERY;
    end else if (!log_full && log_db) begin
      err_log[log_count[LOG_AW-1:0]] <= `SCS_LOG_DATABASE;
    end
  end

  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_rdata <= 16'h0000;
      log_rdata <= 16'h0000;
    end else begin
      ram_rdata <= fb_ram[ram_addr];
      log_rdata <= err_log[log_raddr];
    end
  end

  // error detection and logging
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bat_err <= 1'b0;
      bat_logged <= 1'b0;
      db_pend <= 1'b0;
      db_flag <= 1'b0;
      log_count <= {(LOG_AW+1){1'b0}};
      battery_fault_item <= 1'b0;
      relay_word_bit5 <= 1'b0;
    end else begin
      if (state != `SCS_ST_INIT && state != `SCS_ST_COPY) begin
        if (restore_on) begin
          battery_fault_item <= 1'b1;
          relay_word_bit5 <= 1'b1;
        end else if (bat_stable) begin
          bat_err <= 1'b1;
          battery_fault_item <= 1'b1;
          relay_word_bit5 <= 1'b1;
        end
      end
      if (db_error) begin
        db_flag <= 1'b1;
      end
      if (db_error) begin
        db_pend <= 1'b1;
      end else if (log_db) begin
        db_pend <= 1'b0;
      end
      if (log_bat) begin
        bat_logged <= 1'b1;
      end
      if (!log_full && (log_bat || log_db)) begin
        log_count <= log_count + 1'b1;
      end
    end
  end

  // blink enable divider and lamps
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt <= 32'h00000000;
      blink <= 1'b0;
      fault_run <= 1'b0;
      run_lamp <= 1'b0;
      module_fault_lamp <= 1'b0;
      host_fault_lamp <= 1'b0;
      aux_port_en <= 1'b0;
    end else begin
      if (blink_cnt == BLINK_HALF_CYC - 1) begin
        blink_cnt <= 32'h00000000;
        blink <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 32'h00000001;
      end
      fault_run <= db_flag || hw_fault || wdt_error;
      run_lamp <= running && (state == `SCS_ST_RUN) && supply_ok;
      if (fault_run) begin
        module_fault_lamp <= 1'b1;
      end else if (bat_err && !restore_on) begin
        module_fault_lamp <= blink;
      end else begin
        module_fault_lamp <= 1'b0;
      end
      host_fault_lamp <= host_error;
      aux_port_en <= term_block_present;
    end
  end
endmodule

// *** verification/scs_flash_model.sv ***
// flash memory model holding the saved block data
`timescale 1ns/1ps
module scs_flash_model (
  // clock
  input wire ref_clk,
  // read port
  input wire [5:0] flash_addr,
  output logic [15:0] flash_rdata
);
  // data saved by the operator before pin 2 is set
  always @(posedge ref_clk) begin
    flash_rdata <= 16'h5A40 + {10'h000, flash_addr};
  end
endmodule

// *** verification/scs_startup_config_status_assertions.sv ***
// concurrent checks on the start-up block ports
`timescale 1ns/1ps
module scs_checker (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // inputs
  input wire term_block_present,
  input wire hw_fault,
  // outputs
  input wire node_we,
  input wire [15:0] node_wdata,
  input wire [7:0] unit_address_item,
  input wire battery_fault_item,
  input wire relay_word_bit5,
  input wire aux_port_en,
  input wire cold_only,
  input wire start_refused,
  input wire running,
  input wire run_lamp,
  input wire module_fault_lamp
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_NODE_BURST: assert property (
    $rose(node_we) |-> node_we[*4] ##1 !node_we) else $error("burst");
  AST_NODE_DATA: assert property (
    node_we |-> node_wdata == {8'h00, unit_address_item}) else $error("data");
  AST_RUN_LAMP: assert property (
    run_lamp |-> $past(running)) else $error("run lamp");
  AST_FAULT_HALT: assert property (
    hw_fault |-> ##[0:2] !running) else $error("no halt");
  AST_BAT_PAIR: assert property (
    battery_fault_item == relay_word_bit5) else $error("bat pair");
  AST_BAT_STICKY: assert property (
    !$fell(battery_fault_item)) else $error("bat cleared");
  AST_NO_BLINK: assert property (
    cold_only |-> !$fell(module_fault_lamp)) else $error("blink");
  AST_REFUSE: assert property (
    start_refused |-> cold_only && !running) else $error("refuse");
  AST_AUX: assert property (
    aux_port_en |-> $past(term_block_present)) else $error("aux");
endmodule

// *** verification/scs_startup_config_status_tb.sv ***
// self-checking bench for the start-up block
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module startup_config_status_tb;
  logic ref_clk = 0, sys_rst = 1, restore_sw = 0, battery_low = 0;
  logic start_req = 0, start_cold = 0, stop_req = 0, db_error = 0;
  logic term_block_present = 0, hw_fault = 0, supply_ok = 1;
  logic host_error = 0, host_fault_lamp;
  logic [3:0] unit_sel = 4'h0, sel;
  logic [5:0] ram_addr = 6'h00, flash_addr, k;
  logic [3:0] log_raddr = 4'h0;
  logic [15:0] flash_rdata, ram_rdata, log_rdata, node_addr, node_wdata;
  logic [4:0] log_count;
  logic [7:0] unit_address_item;
  logic node_we, battery_fault_item, relay_word_bit5, aux_port_en;
  logic cold_only, start_refused, running, run_lamp, module_fault_lamp;
  int bad_count = 0, cmp_count = 0, n;
  always #25 ref_clk = ~ref_clk;
  scs_flash_model fl_u (.ref_clk(ref_clk), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata));
  scs_startup_config_status #(.BLINK_HALF_CYC(4)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .unit_sel(unit_sel),
    .restore_sw(restore_sw), .battery_low(battery_low),
    .start_req(start_req), .start_cold(start_cold), .stop_req(stop_req),
    .term_block_present(term_block_present), .db_error(db_error),
    .hw_fault(hw_fault), .wdt_error(1'b0), .supply_ok(supply_ok),
    .host_error(host_error), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata),
    .ram_we(1'b0), .ram_addr(ram_addr), .ram_wdata(16'h0000),
    .ram_rdata(ram_rdata), .log_raddr(log_raddr), .log_rdata(log_rdata),
    .log_count(log_count), .node_we(node_we), .node_addr(node_addr),
    .node_wdata(node_wdata), .unit_address_item(unit_address_item),
    .battery_fault_item(battery_fault_item),
    .relay_word_bit5(relay_word_bit5), .aux_port_en(aux_port_en),
    .cold_only(cold_only), .start_refused(start_refused),
    .running(running), .run_lamp(run_lamp),
    .module_fault_lamp(module_fault_lamp),
    .host_fault_lamp(host_fault_lamp));
  task tick(input int c);
    repeat (c) @(negedge ref_clk);
  endtask
  task boot(input logic p2, input logic bat);
    sel = 4'($urandom);
    @(posedge ref_clk);
    sys_rst <= 1;
    restore_sw <= p2;
    battery_low <= bat;
    unit_sel <= sel;
    hw_fault <= 0;
    supply_ok <= 1;
    host_error <= 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 0;
    tick(p2 ? 110 : 30);
  endtask
  task start(input logic cold, input int nexp);
    int i;
    logic r;
    i = 0;
    r = 0;
    @(posedge ref_clk);
    start_req <= 1;
    start_cold <= cold;
    @(posedge ref_clk);
    start_req <= 0;
    repeat (8) begin
      @(negedge ref_clk);
      r = r | start_refused;
      if (node_we === 1'b1) begin
        `CHK(node_addr, 16'(i) << 8)
        `CHK(node_wdata, {12'h001, sel})
        i++;
      end
    end
    `CHK(i, nexp)
    `CHK(r, 1'(nexp == 0))
    `CHK(running, 1'(nexp != 0))
    `CHK(run_lamp, 1'(nexp != 0))
    if (nexp != 0) `CHK(unit_address_item, {4'h1, sel})
  endtask
  task stop;
    @(posedge ref_clk);
    stop_req <= 1;
    @(posedge ref_clk);
    stop_req <= 0;
    tick(3);
    `CHK(running, 1'b0)
    `CHK(cold_only, 1'b0)
  endtask
  task blinks(output int c);
    logic p;
    c = 0;
    p = module_fault_lamp;
    repeat (24) begin
      @(negedge ref_clk);
      if (module_fault_lamp !== p) c++;
      p = module_fault_lamp;
    end
  endtask
  task read_log(input logic [15:0] e);
    @(posedge ref_clk);
    log_raddr <= 4'h0;
    tick(2);
    `CHK(log_rdata, e)
  endtask
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    n = $urandom(32'hE0C0FA8A);
    boot(0, 1);
    `CHK(battery_fault_item, 1'b1)
    `CHK(relay_word_bit5, 1'b1)
    `CHK(log_count, 5'h01)
    read_log(16'h0330);
    blinks(n);
    `CHK(1'(n >= 4), 1'b1)
    start(1, 4);
    @(posedge ref_clk);
    unit_sel <= ~sel;
    restore_sw <= 1;
    stop;
    start(0, 4);
    $display("test pin2_off done");
    boot(1, 1);
    `CHK(battery_fault_item, 1'b1)
    `CHK(log_count, 5'h00)
    `CHK(cold_only, 1'b1)
    blinks(n);
    `CHK(n, 0)
    k = 6'($urandom);
    @(posedge ref_clk);
    ram_addr <= k;
    tick(2);
    `CHK(ram_rdata, {10'h169, k})
    start(0, 0);
    start(1, 4);
    stop;
    start(0, 4);
    $display("test pin2_on done");
    @(posedge ref_clk);
    db_error <= 1;
    term_block_present <= 1;
    @(posedge ref_clk);
    db_error <= 0;
    tick(4);
    `CHK(log_count, 5'h01)
    read_log(16'h0331);
    `CHK(module_fault_lamp, 1'b1)
    `CHK(aux_port_en, 1'b1)
    @(posedge ref_clk);
    host_error <= 1;
    supply_ok <= 0;
    tick(3);
    `CHK(host_fault_lamp, 1'b1)
    `CHK(running, 1'b0)
    `CHK(run_lamp, 1'b0)
    $display("test faults done");
    boot(0, 0);
    `CHK(battery_fault_item, 1'b0)
    `CHK(relay_word_bit5, 1'b0)
    `CHK(host_fault_lamp, 1'b0)
    blinks(n);
    `CHK(n, 0)
    start(0, 4);
    @(posedge ref_clk);
    hw_fault <= 1;
    tick(3);
    `CHK(running, 1'b0)
    `CHK(run_lamp, 1'b0)
    `CHK(module_fault_lamp, 1'b1)
    $display("test battery_good done");
    end_sim;
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    bad_count++;
    end_sim;
  end
endmodule
bind scs_startup_config_status scs_checker chk_u (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .term_block_present(term_block_present),
  .hw_fault(hw_fault), .node_we(node_we), .node_wdata(node_wdata),
  .unit_address_item(unit_address_item),
  .battery_fault_item(battery_fault_item),
  .relay_word_bit5(relay_word_bit5), .aux_port_en(aux_port_en),
  .cold_only(cold_only), .start_refused(start_refused),
  .running(running), .run_lamp(run_lamp),
  .module_fault_lamp(module_fault_lamp));
